// ### logic/jog_dcb_pkg.sv
// constants, register map and state type for the jog and dc brake input control
package jog_dcb_pkg;
	localparam int CLK_HZ        = 200_000_000;
	localparam int DELAY_UNIT_MS = 100;
	localparam int RAMP_STEP_MS  = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * DELAY_UNIT_MS;
	localparam int RAMP_CYCLES   = CLK_HZ / 1000 * RAMP_STEP_MS;
	localparam int NUM_TERMS     = 6;
	localparam int FN_BITS       = 4;

	// terminal function codes
	localparam logic [3:0] FN_FWD = 4'h0;
	localparam logic [3:0] FN_REV = 4'h1;
	localparam logic [3:0] FN_JOG = 4'h6;
	localparam logic [3:0] FN_DCB = 4'h7;

	// run command source and jog stop modes
	localparam logic [1:0] SRC_TERMINAL = 2'h1;
	localparam logic [1:0] SRC_KEYPAD   = 2'h2;
	localparam logic [1:0] STOP_COAST   = 2'h0;
	localparam logic [1:0] STOP_DECEL   = 2'h1;
	localparam logic [1:0] STOP_DCB     = 2'h2;

	// frequencies in 0.1 Hz, delay in 0.1 s, force in percent
	localparam logic [15:0] JOG_MAX_FREQ   = 16'h0064;
	localparam logic [15:0] JOG_ADVISED    = 16'h0032;
	localparam logic [7:0]  DCB_DELAY_MIN  = 8'h01;
	localparam logic [7:0]  DCB_DELAY_MAX  = 8'h32;
	localparam logic [7:0]  DCB_FORCE_MAX  = 8'h64;

	// register byte offsets
	localparam logic [7:0] ADDR_RUN_CFG    = 8'h00;
	localparam logic [7:0] ADDR_TERM_MAP   = 8'h04;
	localparam logic [7:0] ADDR_JOG_FREQ   = 8'h08;
	localparam logic [7:0] ADDR_START_FREQ = 8'h0C;
	localparam logic [7:0] ADDR_JOG_STOP   = 8'h10;
	localparam logic [7:0] ADDR_DCB_DELAY  = 8'h14;
	localparam logic [7:0] ADDR_DCB_FORCE  = 8'h18;
	localparam logic [7:0] ADDR_SET_FREQ   = 8'h1C;
	localparam logic [7:0] ADDR_STATUS     = 8'h20;
	localparam logic [7:0] ADDR_OUT_FREQ   = 8'h24;

	// reset values
	localparam logic [31:0] RST_TERM_MAP   = 32'hFFFF_7610;
	localparam logic [1:0]  RST_RUN_SRC    = 2'h1;
	localparam logic [7:0]  RST_DCB_DELAY  = 8'h05;
	localparam logic [7:0]  RST_DCB_FORCE  = 8'h32;
	localparam logic [15:0] RST_JOG_FREQ   = 16'h0032;
	localparam logic [15:0] RST_START_FREQ = 16'h0005;

	// field positions
	localparam int RUN_KEY_BIT  = 8;
	localparam int STS_OUT_ON   = 0;
	localparam int STS_BRAKE    = 1;
	localparam int STS_JOG_OK   = 2;
	localparam int STS_JOG_HIGH = 3;
	localparam int STS_STATE    = 8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_JOG,
		ST_DECEL,
		ST_DCB_TIMED,
		ST_COAST_WAIT,
		ST_BRAKE,
		ST_HOLD_OFF
	} state_type;
endpackage : jog_dcb_pkg

// ### logic/jog_dcb_ctrl.sv
// jog command and external dc brake control behind a wishbone register file
// How it works
// - jog output frequency never above 10 Hz
// - jog target comes from jog frequency register
// - jog frequency applied at once, no ramp
// - jog input plus run drives jog frequency
// - jog only honoured with terminal run source
// - jog ends by coast, decel or dc brake
// - function code six assigns jog to terminal
// - no jog below start frequency or zero
// - any of six terminals takes any function
// - code seven input enables dc braking only
// - braking delay held within 0.1 to 5.0 s
// - braking force held within 0 to 100 percent
// - terminal run: brake, then ramp back up
// - keypad run: output stays off after brake
// - keypad run: coast for delay, then brake
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module jog_dcb_ctrl
	import jog_dcb_pkg::*;
#(
	parameter int num_terms_p   = NUM_TERMS,
	parameter int tick_cycles_p = TICK_CYCLES,
	parameter int ramp_cycles_p = RAMP_CYCLES
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// wishbone slave
	input  wire logic [7:0]             adr_i,
	input  wire logic [31:0]            dat_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic                   we_i,
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	output logic      [31:0]            dat_o,
	output logic                        ack_o,
	// input terminals
	input  wire logic [num_terms_p-1:0] term_i,
	// drive stage
	output logic      [15:0]            out_freq_o,
	output logic                        out_on_o,
	output logic                        reverse_o,
	output logic                        dc_brake_o,
	output logic      [7:0]             dc_force_o
);
	localparam int MAPW = FN_BITS * num_terms_p;

	if (num_terms_p < 1 || num_terms_p > 8
		|| tick_cycles_p < 1 || ramp_cycles_p < 1) begin : g_bad_params
		$error("jog_dcb_ctrl: unsupported parameter values");
	end

	function automatic logic fn_hit(input logic [MAPW-1:0] map,
		input logic [num_terms_p-1:0] t, input logic [3:0] code);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < num_terms_p; k++) begin
			if (t[k] && map[FN_BITS*k +: FN_BITS] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : fn_hit

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] clamp8(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp8

	function automatic logic [15:0] step(input logic [15:0] cur, input logic [15:0] tgt);
		if (cur < tgt) begin
			return cur + 16'h0001;
		end
		if (cur > tgt) begin
			return cur - 16'h0001;
		end
		return cur;
	endfunction : step

	logic [num_terms_p-1:0] term_meta;
	logic [num_terms_p-1:0] term_sync;
	logic                   ack;
	logic                   take;
	logic [31:0]            rdata;
	logic [31:0]            wd;
	logic [1:0]             run_src;
	logic                   run_key;
	logic [MAPW-1:0]        term_map;
	logic [15:0]            jog_freq;
	logic [15:0]            start_freq;
	logic [1:0]             stop_mode;
	logic [7:0]             dcb_delay;
	logic [7:0]             dcb_force;
	logic [15:0]            set_freq;
	state_type              state;
	state_type              next_state;
	state_type              brake_entry;
	logic [31:0]            pre_cnt;
	logic [7:0]             tenths;
	logic                   timer_done;
	logic [31:0]            ramp_cnt;
	logic                   ramp_tick;
	logic                   fwd;
	logic                   rev;
	logic                   jog_in;
	logic                   dcb_in;
	logic                   term_run;
	logic                   run_cmd;
	logic                   jog_ok;
	logic                   jog_req;
	logic [15:0]            jog_target;

	// switch levels are asynchronous; only term_sync feeds decisions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_meta <= '0;
			term_sync <= '0;
		end else begin
			term_meta <= term_i;
			term_sync <= term_meta;
		end
	end

	assign fwd      = fn_hit(term_map, term_sync, FN_FWD);
	assign rev      = fn_hit(term_map, term_sync, FN_REV);
	assign jog_in   = fn_hit(term_map, term_sync, FN_JOG);
	assign dcb_in   = fn_hit(term_map, term_sync, FN_DCB);
	// both directions at once means stop
	assign term_run = fwd ^ rev;
	assign run_cmd  = (run_src == SRC_TERMINAL) ? term_run : run_key;
	assign jog_ok   = (jog_freq != 16'h0000) && (jog_freq >= start_freq);
	assign jog_req  = jog_in && jog_ok && (run_src == SRC_TERMINAL)
		&& (term_run || run_key);
	assign jog_target = (jog_freq > JOG_MAX_FREQ) ? JOG_MAX_FREQ : jog_freq;
	assign brake_entry = (run_src == SRC_TERMINAL) ? ST_BRAKE : ST_COAST_WAIT;

	// wishbone: one wait state, ack drops the cycle after it is given
	assign take  = cyc_i & stb_i & ~ack;
	assign ack_o = ack;
	assign wd    = merge(rdata, dat_i, sel_i);

	always_comb begin
		rdata = 32'h0000_0000;
		case (adr_i)
			ADDR_RUN_CFG: begin
				rdata[1:0]         = run_src;
				rdata[RUN_KEY_BIT] = run_key;
			end
			ADDR_TERM_MAP:   rdata = 32'(term_map);
			ADDR_JOG_FREQ:   rdata = {16'h0000, jog_freq};
			ADDR_START_FREQ: rdata = {16'h0000, start_freq};
			ADDR_JOG_STOP:   rdata = {30'h0000_0000, stop_mode};
			ADDR_DCB_DELAY:  rdata = {24'h00_0000, dcb_delay};
			ADDR_DCB_FORCE:  rdata = {24'h00_0000, dcb_force};
			ADDR_SET_FREQ:   rdata = {16'h0000, set_freq};
			ADDR_STATUS: begin
				rdata[STS_OUT_ON]         = out_on_o;
				rdata[STS_BRAKE]          = dc_brake_o;
				rdata[STS_JOG_OK]         = jog_ok;
				rdata[STS_JOG_HIGH]       = jog_freq > JOG_ADVISED;
				rdata[STS_STATE +: 3]     = 3'(state);
			end
			ADDR_OUT_FREQ:   rdata = {16'h0000, out_freq_o};
			default:         rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack <= take;
			if (take && !we_i) begin
				dat_o <= rdata;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_src    <= RST_RUN_SRC;
			run_key    <= 1'b0;
			term_map   <= RST_TERM_MAP[MAPW-1:0];
			jog_freq   <= RST_JOG_FREQ;
			start_freq <= RST_START_FREQ;
			stop_mode  <= STOP_COAST;
			dcb_delay  <= RST_DCB_DELAY;
			dcb_force  <= RST_DCB_FORCE;
			set_freq   <= 16'h0000;
		end else if (take && we_i) begin
			case (adr_i)
				ADDR_RUN_CFG: begin
					run_src <= wd[1:0];
					run_key <= wd[RUN_KEY_BIT];
				end
				ADDR_TERM_MAP:   term_map   <= wd[MAPW-1:0];
				ADDR_JOG_FREQ:   jog_freq   <= wd[15:0];
				ADDR_START_FREQ: start_freq <= wd[15:0];
				ADDR_JOG_STOP:   stop_mode  <= wd[1:0];
				ADDR_DCB_DELAY:  dcb_delay  <= clamp8(wd[7:0], DCB_DELAY_MIN, DCB_DELAY_MAX);
				ADDR_DCB_FORCE:  dcb_force  <= clamp8(wd[7:0], 8'h00, DCB_FORCE_MAX);
				ADDR_SET_FREQ:   set_freq   <= wd[15:0];
				default: ;
			endcase
		end
	end

	// braking always wins over jog, and jog over a plain run
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (dcb_in) begin
					next_state = brake_entry;
				end else if (jog_req) begin
					next_state = ST_JOG;
				end else if (run_cmd) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (dcb_in) begin
					next_state = brake_entry;
				end else if (jog_req) begin
					next_state = ST_JOG;
				end else if (!run_cmd) begin
					next_state = ST_DECEL;
				end
			end
			ST_JOG: begin
				if (dcb_in) begin
					next_state = brake_entry;
				end else if (!jog_req) begin
					case (stop_mode)
						STOP_COAST: next_state = ST_IDLE;
						STOP_DCB:   next_state = ST_DCB_TIMED;
						default:    next_state = ST_DECEL;
					endcase
				end
			end
			ST_DECEL: begin
				if (dcb_in) begin
					next_state = brake_entry;
				end else if (jog_req) begin
					next_state = ST_JOG;
				end else if (run_cmd) begin
					next_state = ST_RUN;
				end else if (out_freq_o == 16'h0000) begin
					next_state = ST_IDLE;
				end
			end
			ST_DCB_TIMED: begin
				if (timer_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_COAST_WAIT: begin
				if (!dcb_in) begin
					next_state = ST_HOLD_OFF;
				end else if (timer_done) begin
					next_state = ST_BRAKE;
				end
			end
			ST_BRAKE: begin
				if (!dcb_in) begin
					if (run_src != SRC_TERMINAL) begin
						next_state = ST_HOLD_OFF;
					end else if (run_cmd) begin
						next_state = ST_RUN;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_HOLD_OFF: begin
				// keypad run key must be dropped before a restart
				if (!dcb_in && !run_key) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// delay timer restarts on every state change, counts in 0.1 s units
	assign timer_done = tenths >= dcb_delay;
	always_ff @(posedge clk_i) begin
		if (rst_i || state != next_state) begin
			pre_cnt <= 32'h0000_0000;
			tenths  <= 8'h00;
		end else if (pre_cnt == 32'(tick_cycles_p - 1)) begin
			pre_cnt <= 32'h0000_0000;
			if (tenths != 8'hFF) begin
				tenths <= tenths + 8'h01;
			end
		end else begin
			pre_cnt <= pre_cnt + 32'h0000_0001;
		end
	end

	assign ramp_tick = ramp_cnt == 32'(ramp_cycles_p - 1);
	always_ff @(posedge clk_i) begin
		if (rst_i || ramp_tick) begin
			ramp_cnt <= 32'h0000_0000;
		end else begin
			ramp_cnt <= ramp_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_freq_o <= 16'h0000;
		end else begin
			case (state)
				ST_RUN: begin
					if (ramp_tick) begin
						out_freq_o <= step(out_freq_o, set_freq);
					end
				end
				ST_JOG:   out_freq_o <= jog_target;
				ST_DECEL: begin
					if (ramp_tick) begin
						out_freq_o <= step(out_freq_o, 16'h0000);
					end
				end
				default:  out_freq_o <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_on_o   <= 1'b0;
			dc_brake_o <= 1'b0;
			dc_force_o <= 8'h00;
			reverse_o  <= 1'b0;
		end else begin
			out_on_o   <= state == ST_RUN || state == ST_JOG || state == ST_DECEL;
			dc_brake_o <= state == ST_BRAKE || state == ST_DCB_TIMED;
			dc_force_o <= (state == ST_BRAKE || state == ST_DCB_TIMED) ? dcb_force : 8'h00;
			if (run_src == SRC_TERMINAL && term_run) begin
				reverse_o <= rev;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_off_next;
		##1 (!out_on_o && !dc_brake_o);
	endsequence

	property p_jog_cap;
		$past(state) == ST_JOG |-> out_freq_o <= JOG_MAX_FREQ;
	endproperty
	a_jog_cap: assert property (p_jog_cap) else $error("jog frequency above cap");

	property p_jog_direct;
		state == ST_JOG |=> out_freq_o == $past(jog_target);
	endproperty
	a_jog_direct: assert property (p_jog_direct) else $error("jog not applied at once");

	property p_jog_start;
		state == ST_IDLE && jog_req && !dcb_in |=> state == ST_JOG ##1 out_on_o;
	endproperty
	a_jog_start: assert property (p_jog_start) else $error("jog request not served");

	property p_jog_source;
		state != ST_JOG && run_src != SRC_TERMINAL |=> state != ST_JOG;
	endproperty
	a_jog_source: assert property (p_jog_source) else $error("jog with wrong source");

	property p_jog_coast;
		state == ST_JOG && !jog_req && !dcb_in && stop_mode == STOP_COAST
			|=> state == ST_IDLE ##0 s_off_next;
	endproperty
	a_jog_coast: assert property (p_jog_coast) else $error("jog coast stop wrong");

	property p_jog_dcb;
		state == ST_JOG && !jog_req && !dcb_in && stop_mode == STOP_DCB
			|=> state == ST_DCB_TIMED ##1 dc_brake_o;
	endproperty
	a_jog_dcb: assert property (p_jog_dcb) else $error("jog brake stop wrong");

	property p_jog_refused;
		!jog_ok |=> state != ST_JOG;
	endproperty
	a_jog_refused: assert property (p_jog_refused) else $error("jog below start freq");

	property p_brake_needs_input;
		state == ST_BRAKE && !dcb_in |=> state != ST_BRAKE ##1 !dc_brake_o;
	endproperty
	a_brake_needs_input: assert property (p_brake_needs_input) else $error("brake held");

	property p_limits;
		dcb_delay >= DCB_DELAY_MIN && dcb_delay <= DCB_DELAY_MAX
			&& dc_force_o <= DCB_FORCE_MAX && (dc_brake_o || dc_force_o == 8'h00);
	endproperty
	a_limits: assert property (p_limits) else $error("delay or force out of range");

	property p_term_resume;
		state == ST_BRAKE && !dcb_in && run_src == SRC_TERMINAL && run_cmd
			|=> state == ST_RUN && out_freq_o == 16'h0000 ##1 out_on_o;
	endproperty
	a_term_resume: assert property (p_term_resume) else $error("no ramp after brake");

	property p_keypad_off;
		state == ST_BRAKE && !dcb_in && run_src != SRC_TERMINAL
			|=> state == ST_HOLD_OFF ##0 s_off_next;
	endproperty
	a_keypad_off: assert property (p_keypad_off) else $error("keypad output restarted");

	property p_keypad_coast;
		state == ST_COAST_WAIT && $past(state) == ST_COAST_WAIT |-> !dc_brake_o && !out_on_o;
	endproperty
	a_keypad_coast: assert property (p_keypad_coast) else $error("not coasting");

	property p_sync;
		// reset clears both stages, so pin history means nothing for two edges
		!$past(rst_i) && !$past(rst_i, 2) |-> term_sync == $past(term_i, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("terminal sync depth wrong");
endmodule : jog_dcb_ctrl

// ### dv/terminal_switches.sv
// behavioural model of the switches and controller that drive the input terminals
`timescale 1ns/1ps
module terminal_switches #(
	parameter int n_p         = 6,
	parameter int brake_bit_p = 3,
	parameter int brake_max_p = 2000
) (
	// clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// requested levels, jog terminals, motor state
	input  wire logic [n_p-1:0] want_i,
	input  wire logic [n_p-1:0] jog_mask_i,
	input  wire logic           out_on_i,
	// terminal levels
	output logic      [n_p-1:0] term_o
);
	int held;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_o <= '0;
			held   <= 0;
		end else begin
			for (int k = 0; k < n_p; k++) begin
				// jog is only switched on while the motor stands
				if (!(jog_mask_i[k] && want_i[k] && !term_o[k] && out_on_i))
					term_o[k] <= want_i[k];
			end
			// the brake is never used as a holding brake
			if (held >= brake_max_p)
				term_o[brake_bit_p] <= 1'b0;
			held <= term_o[brake_bit_p] ? held + 1 : 0;
		end
	end
endmodule : terminal_switches

// ### dv/test_jog_dcb_ctrl.sv
// self-checking bench for the jog and dc brake input control
`timescale 1ns/1ps
module test_jog_dcb_ctrl;
	import jog_dcb_pkg::*;
	typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_type;
	localparam logic [5:0] FWD = 6'h01;
	localparam logic [5:0] JOG = 6'h04;
	localparam logic [5:0] BRK = 6'h08;
	localparam logic [5:0] T6  = 6'h20;
	logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
	logic        out_on_o, reverse_o, dc_brake_o;
	logic [7:0]  adr_i, dc_force_o;
	logic [31:0] dat_i, dat_o, q;
	logic [15:0] out_freq_o, f, e;
	logic [5:0]  term, want, jmask;
	int          n_mismatch, samples_checked, n;
	// only the six implemented terminal fields read back
	row_type     rows[17] = '{
		'{8'h00, 1'b0, 0, 1}, '{8'h04, 1'b0, 0, 32'h00FF_7610}, '{8'h08, 1'b0, 0, 32'h32},
		'{8'h0C, 1'b0, 0, 5}, '{8'h10, 1'b0, 0, 0}, '{8'h14, 1'b0, 0, 5},
		'{8'h18, 1'b0, 0, 32'h32}, '{8'h1C, 1'b0, 0, 0}, '{8'h24, 1'b0, 0, 0},
		'{8'h14, 1'b1, 0, 1}, '{8'h14, 1'b1, 32'hFF, 32'h32}, '{8'h14, 1'b1, 5, 5},
		'{8'h18, 1'b1, 32'hC8, 32'h64}, '{8'h18, 1'b1, 32'h32, 32'h32},
		'{8'h40, 1'b1, 32'h1234, 0}, '{8'h24, 1'b1, 32'h55, 0},
		'{8'h20, 1'b1, 32'hFFFF, 32'h4}};
	logic [15:0] jf[4] = '{16'h0000, 16'h0004, 16'h0005, 16'h00C8};

	jog_dcb_ctrl #(.num_terms_p(6), .tick_cycles_p(10), .ramp_cycles_p(2)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hF),
		.we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.term_i(term), .out_freq_o(out_freq_o), .out_on_o(out_on_o),
		.reverse_o(reverse_o), .dc_brake_o(dc_brake_o), .dc_force_o(dc_force_o));

	terminal_switches i_sw (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
		.jog_mask_i(jmask), .out_on_i(out_on_o), .term_o(term));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic give_up();
		n_mismatch++;
		$display("[ERR] %0t wait ran out", $time);
		wrap_up();
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		adr_i <= a;
		we_i  <= w;
		dat_i <= d;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1)
			give_up();
	endtask : wb

	// s selects the output: 0 out_on, 1 dc_brake, 2 out_freq
	task automatic wait_for(input int s, input logic [15:0] v, input int lim);
		logic [15:0] cur;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			cur = (s == 0) ? 16'(out_on_o) : (s == 1) ? 16'(dc_brake_o) : out_freq_o;
		end while (cur !== v && n < lim);
		if (cur !== v)
			give_up();
	endtask : wait_for

	task automatic idle();
		wait_for(0, 16'h0, 400);
		wait_for(1, 16'h0, 400);
	endtask : idle

	initial begin
		rst_i = 1'b1;
		adr_i = '0;
		dat_i = '0;
		we_i = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		want = '0;
		jmask = JOG;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w)
				wb(rows[i].a, 1'b1, rows[i].d);
			wb(rows[i].a, 1'b0, 0);
			check(q, rows[i].e);
		end
		$display("test registers done");
		// mode 3 is served as a plain deceleration
		for (int m = 0; m < 4; m++) begin
			wb(ADDR_JOG_STOP, 1'b1, 32'(m));
			want <= FWD | JOG;
			wait_for(0, 16'h1, 20);
			check(out_freq_o, RST_JOG_FREQ);
			want <= '0;
			repeat (8) @(posedge clk_i);
			check(out_on_o, m == 1 || m == 3);
			check(dc_brake_o, m == 2);
			check(dc_force_o, (m == 2) ? RST_DCB_FORCE : 8'h00);
			idle();
		end
		wb(ADDR_JOG_STOP, 1'b1, 32'(STOP_COAST));
		$display("test stop modes done");
		foreach (jf[i]) begin
			f = jf[i];
			e = (f == 0 || f < RST_START_FREQ) ? 16'h0 : (f > JOG_MAX_FREQ) ? JOG_MAX_FREQ : f;
			wb(ADDR_JOG_FREQ, 1'b1, 32'(f));
			want <= FWD | JOG;
			repeat (10) @(posedge clk_i);
			check(out_freq_o, e);
			want <= '0;
			idle();
		end
		wb(ADDR_JOG_FREQ, 1'b1, 32'(RST_JOG_FREQ));
		$display("test jog limits done");
		wb(ADDR_RUN_CFG, 1'b1, 32'(SRC_KEYPAD));
		want <= FWD | JOG;
		repeat (10) @(posedge clk_i);
		check(out_on_o, 0);
		want <= '0;
		wb(ADDR_RUN_CFG, 1'b1, 32'(SRC_TERMINAL));
		wb(ADDR_TERM_MAP, 1'b1, 32'hFF6F_FF10);
		jmask <= T6;
		want <= FWD | T6;
		wait_for(0, 16'h1, 20);
		check(out_freq_o, RST_JOG_FREQ);
		want <= '0;
		idle();
		wb(ADDR_TERM_MAP, 1'b1, RST_TERM_MAP);
		jmask <= JOG;
		$display("test source and mapping done");
		// terminal run: brake then ramp back to the earlier speed
		wb(ADDR_SET_FREQ, 1'b1, 32'h14);
		want <= FWD;
		wait_for(2, 16'h14, 200);
		check(dc_brake_o, 0);
		want <= FWD | BRK;
		wait_for(1, 16'h1, 20);
		check(dc_force_o, RST_DCB_FORCE);
		check(out_on_o, 0);
		want <= FWD;
		wait_for(0, 16'h1, 20);
		check(out_freq_o < 16'h14, 1);
		wait_for(2, 16'h14, 200);
		want <= '0;
		idle();
		$display("test terminal brake done");
		// keypad run: coast for the delay, brake, then stay off
		wb(ADDR_RUN_CFG, 1'b1, (32'h1 << RUN_KEY_BIT) | 32'(SRC_KEYPAD));
		wait_for(2, 16'h14, 200);
		want <= BRK;
		repeat (8) @(posedge clk_i);
		check(out_on_o, 0);
		check(dc_brake_o, 0);
		wait_for(1, 16'h1, 100);
		check(n > 30, 1);
		want <= '0;
		repeat (20) @(posedge clk_i);
		check(out_on_o, 0);
		check(dc_brake_o, 0);
		wb(ADDR_RUN_CFG, 1'b1, 32'(SRC_TERMINAL));
		$display("test keypad brake done");
		want <= 6'h02;
		wait_for(0, 16'h1, 20);
		check(reverse_o, 1);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({out_freq_o, out_on_o, dc_brake_o, dc_force_o, reverse_o}, 0);
		want <= '0;
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		check(out_on_o, 0);
		$display("test reset done");
		wrap_up();
	end
endmodule : test_jog_dcb_ctrl
